// ### crs_pkg.sv
// Constants, state types and parity helper shared by both ends of the sideband link.
// Assumes one bus clock at CLK_PERIOD_NS drives both ends.
package crs_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_MIN_US    = 1000;
    localparam int RST_MAX_US    = 10000;
    localparam int RST_HOLD_US   = 2000;
    localparam int RST_MIN_CYC   = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_MAX_CYC   = (RST_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int RST_HOLD_CYC  = (RST_HOLD_US * 1000) / CLK_PERIOD_NS;
    // Config must outlast the far end's four-edge synchroniser plus its latch edge
    localparam int CFG_HOLD_CYC  = 6;
    localparam int CFG_W         = 8;
    localparam int REQ_W         = 5;
    localparam int STB_W         = 2;
    localparam int RSP_W         = 3;

    // Synchroniser slots and their reset levels
    localparam int SY_PWR = 0;
    localparam int SY_RST = 1;
    localparam int SY_SMI = 2;
    localparam int SY_HLT = 3;
    localparam int SY_N   = 4;
    localparam logic [SY_N-1:0] SYNC_RST = 4'hc;

    localparam logic [REQ_W-1:0] CMD_SMI_ACK  = 5'h08;
    localparam logic [REQ_W-1:0] CMD_HALT_ACK = 5'h09;
    localparam logic [RSP_W-1:0] RS_IDLE      = 3'h0;

    typedef enum logic [6:0] {
        ST_RESET    = 7'h01,
        ST_RUN      = 7'h02,
        ST_SMI_ACK  = 7'h04,
        ST_SMM      = 7'h08,
        ST_HALT_ACK = 7'h10,
        ST_HALT     = 7'h20,
        ST_TRISTATE = 7'h40
    } crs_dev_state_t;

    typedef enum logic [3:0] {
        HS_OFF   = 4'h1,
        HS_RESET = 4'h2,
        HS_CFG   = 4'h4,
        HS_RUN   = 4'h8
    } crs_host_state_t;

    // Parity pin level: high when an even number of status lines are low
    function automatic logic crs_rsp_parity(input logic [RSP_W-1:0] status_n);
        return ~(^(~status_n));
    endfunction
endpackage

// ### crs_sideband_if.sv
// Sideband and bus-pin bundle between the processor end and the chipset end.
// Shared lines are modelled with pull-ups: a released driver reads as all ones.
`timescale 1ns/1ps
`default_nettype none
interface crs_sideband_if
    import crs_pkg::*;
#(
    parameter int CW = CFG_W
);
    // Chipset-driven sideband levels
    logic             power_ok;
    logic             reset_n;
    logic             sys_mgmt_irq_n;
    logic             clock_halt_req_n;
    // Chipset drivers
    logic [CW-1:0]    cfg_out;
    logic             cfg_oe_n;
    logic [RSP_W-1:0] rsp_status_out;
    logic             rsp_parity_out;
    logic             rsp_oe_n;
    // Processor drivers
    logic [REQ_W-1:0] req_out;
    logic             req_oe_n;
    logic [STB_W-1:0] stb_out;
    logic             stb_oe_n;
    // Resolved wire levels
    logic [CW-1:0]    config_bus;
    logic [RSP_W-1:0] response_status_n;
    logic             response_parity_n;
    logic [REQ_W-1:0] request_cmd_n;
    logic [STB_W-1:0] address_strobe_n;

    assign config_bus        = cfg_oe_n ? '1 : cfg_out;
    assign response_status_n = rsp_oe_n ? '1 : rsp_status_out;
    assign response_parity_n = rsp_oe_n ? 1'b1 : rsp_parity_out;
    assign request_cmd_n     = req_oe_n ? '1 : req_out;
    assign address_strobe_n  = stb_oe_n ? '1 : stb_out;

    modport dev_mp (
        input  power_ok, reset_n, sys_mgmt_irq_n, clock_halt_req_n,
        input  config_bus, response_status_n, response_parity_n,
        output req_out, req_oe_n, stb_out, stb_oe_n
    );
    modport host_mp (
        output power_ok, reset_n, sys_mgmt_irq_n, clock_halt_req_n,
        output cfg_out, cfg_oe_n, rsp_status_out, rsp_parity_out, rsp_oe_n,
        input  request_cmd_n, address_strobe_n
    );
endinterface
`default_nettype wire

// ### crs_cpu_end.sv
// Processor end: sideband reset sequencing, config capture, management and halt states.
// Assumes the chipset end on the same bus clock; sideband pins are treated as asynchronous.
//
// Contract
// - Chipset holds power_ok low, glitch-free, then rises.
// - power_ok may drop; stable before next rise.
// - Each power_ok rise followed by 1-10 ms reset.
// - Chipset keeps power_ok high during boundary scan.
// - Reset restores state, invalidates caches without writeback.
// - Power-on reset held at least 1 ms.
// - Outputs released within two clocks of reset; this end releases them five clocks after reset is sampled low.
// - Reset never held over 10 ms with power_ok.
// - Config latched at reset release; chipset presents it.
// - Responder drives status and parity together.
// - Parity high for even count of low lines.
// - Idle status reads parity high, counted correct.
// - Management interrupt: save, acknowledge, enter management state.
// - Interrupt at reset release tri-states all outputs.
// - Halt request: grant acknowledge, gate core clocks.
// - Halted device still snoops and services interrupts.
// - Halt removal restarts clocks; bus clock untouched.
// - Halt and interrupt inputs accepted asynchronously.
// - Bus owner drives command with address strobes.
`timescale 1ns/1ps
`default_nettype none
module crs_cpu_end
    import crs_pkg::*;
#(
    parameter int CW = CFG_W
)(
    // Clock, reset, enable
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // Link
    crs_sideband_if.dev_mp        bus,
    // Core-side requests
    input  wire logic             i_user_req,
    input  wire logic [REQ_W-1:0] i_user_cmd,
    input  wire logic             i_smm_exit,
    output logic                  o_req_ready,
    // Core-side status
    output logic                  o_core_reset,
    output logic                  o_cache_inval,
    output logic [CW-1:0]         o_cfg,
    output logic                  o_cfg_valid,
    output logic                  o_sys_mgmt_state,
    output logic                  o_state_save,
    output logic                  o_core_clk_en,
    output logic                  o_snoop_en,
    output logic                  o_irq_service_en,
    output logic                  o_outputs_tristate,
    output logic [RSP_W-1:0]      o_rsp_status,
    output logic                  o_rsp_valid,
    output logic                  o_parity_err
);
    if (CW < 1) begin : g_chk
        $error("crs_cpu_end: CW must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers: four flops, a change counts once stages two and three agree
    logic [SY_N-1:0] raw_in;
    logic [SY_N-1:0] filt;
    assign raw_in = {bus.clock_halt_req_n, bus.sys_mgmt_irq_n, bus.reset_n, bus.power_ok};

    for (genvar g = 0; g < SY_N; g++) begin : g_sync
        logic s1_ff;
        logic s2_ff;
        logic s3_ff;
        logic f_ff;
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                s1_ff <= SYNC_RST[g];
                s2_ff <= SYNC_RST[g];
                s3_ff <= SYNC_RST[g];
                f_ff  <= SYNC_RST[g];
            end else if (i_ce) begin
                s1_ff <= raw_in[g];
                s2_ff <= s1_ff;
                s3_ff <= s2_ff;
                if (s2_ff == s3_ff) begin
                    f_ff <= s3_ff;
                end
            end
        end
        assign filt[g] = f_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded events
    crs_dev_state_t state_ff;
    crs_dev_state_t nxt_state;
    logic           smi_prev_ff;
    logic           smi_pend_ff;
    logic           nxt_smi_pend;
    logic           req_ready_ff;

    wire in_reset    = !filt[SY_PWR] || !filt[SY_RST];
    wire smi_fall    = smi_prev_ff && !filt[SY_SMI];
    wire halt_active = !filt[SY_HLT];
    wire user_take   = (state_ff == ST_RUN) && i_user_req && req_ready_ff;
    wire issue_smi   = (state_ff == ST_SMI_ACK);
    wire issue_halt  = (state_ff == ST_HALT_ACK);
    wire issue_any   = issue_smi || issue_halt || user_take;
    wire rs_active   = (bus.response_status_n != ~RS_IDLE);
    wire rs_par_ok   = (bus.response_parity_n == crs_rsp_parity(bus.response_status_n));
    wire [REQ_W-1:0] issue_cmd = issue_smi  ? CMD_SMI_ACK  :
                                 issue_halt ? CMD_HALT_ACK : i_user_cmd;

    // A new interrupt edge wins over the clear on acknowledge entry
    assign nxt_smi_pend = smi_fall || (smi_pend_ff && (nxt_state != ST_SMI_ACK));

    ////////////////////////////////////////////////////////////////////////////
    // Main state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET: begin
                if (!in_reset) begin
                    // Interrupt held low at release parks the pins
                    nxt_state = filt[SY_SMI] ? ST_RUN : ST_TRISTATE;
                end
            end
            ST_RUN: begin
                if (user_take) begin
                    nxt_state = ST_RUN;
                end else if (smi_pend_ff) begin
                    nxt_state = ST_SMI_ACK;
                end else if (halt_active) begin
                    nxt_state = ST_HALT_ACK;
                end
            end
            ST_SMI_ACK:  nxt_state = ST_SMM;
            ST_SMM: begin
                if (i_smm_exit) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HALT_ACK: nxt_state = ST_HALT;
            ST_HALT: begin
                // Interrupts are still serviced while halted
                if (smi_pend_ff) begin
                    nxt_state = ST_SMI_ACK;
                end else if (!halt_active) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_TRISTATE: nxt_state = ST_TRISTATE;
            default:     nxt_state = ST_RESET;
        endcase
        if (in_reset) begin
            nxt_state = ST_RESET;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff     <= ST_RESET;
            smi_prev_ff  <= 1'b1;
            smi_pend_ff  <= 1'b0;
            req_ready_ff <= 1'b0;
        end else if (i_ce) begin
            state_ff     <= nxt_state;
            smi_prev_ff  <= filt[SY_SMI];
            smi_pend_ff  <= nxt_smi_pend && !in_reset;
            req_ready_ff <= (nxt_state == ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus pins: one-cycle command with both strobes, released on reset
    logic [REQ_W-1:0] req_out_ff;
    logic             req_oe_n_ff;
    logic [STB_W-1:0] stb_out_ff;
    logic             stb_oe_n_ff;

    wire drive_ok = !in_reset && (state_ff != ST_TRISTATE);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_out_ff  <= '1;
            req_oe_n_ff <= 1'b1;
            stb_out_ff  <= '1;
            stb_oe_n_ff <= 1'b1;
        end else if (i_ce) begin
            // Release lands one edge after reset is seen
            req_oe_n_ff <= !(issue_any && drive_ok);
            stb_oe_n_ff <= !(issue_any && drive_ok);
            req_out_ff  <= (issue_any && drive_ok) ? ~issue_cmd : '1;
            stb_out_ff  <= (issue_any && drive_ok) ? '0 : '1;
        end
    end

    assign bus.req_out  = req_out_ff;
    assign bus.req_oe_n = req_oe_n_ff;
    assign bus.stb_out  = stb_out_ff;
    assign bus.stb_oe_n = stb_oe_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Core-side outputs
    logic             was_reset_ff;
    logic [CW-1:0]    cfg_ff;
    logic             cfg_valid_ff;
    logic             core_reset_ff;
    logic             cache_inval_ff;
    logic             mgmt_ff;
    logic             save_ff;
    logic             clk_en_ff;
    logic             snoop_ff;
    logic             tri_ff;
    logic [RSP_W-1:0] rsp_status_ff;
    logic             rsp_valid_ff;
    logic             par_err_ff;

    wire release_edge = was_reset_ff && !in_reset;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            was_reset_ff   <= 1'b1;
            cfg_ff         <= '0;
            cfg_valid_ff   <= 1'b0;
            core_reset_ff  <= 1'b1;
            cache_inval_ff <= 1'b1;
            mgmt_ff        <= 1'b0;
            save_ff        <= 1'b0;
            clk_en_ff      <= 1'b0;
            snoop_ff       <= 1'b0;
            tri_ff         <= 1'b0;
            rsp_status_ff  <= RS_IDLE;
            rsp_valid_ff   <= 1'b0;
            par_err_ff     <= 1'b0;
        end else if (i_ce) begin
            was_reset_ff   <= in_reset;
            if (release_edge) begin
                cfg_ff <= bus.config_bus;
            end
            cfg_valid_ff   <= (cfg_valid_ff || release_edge) && !in_reset;
            core_reset_ff  <= in_reset;
            cache_inval_ff <= in_reset;
            mgmt_ff        <= (nxt_state == ST_SMI_ACK) || (nxt_state == ST_SMM);
            save_ff        <= (nxt_state == ST_SMI_ACK) && (state_ff != ST_SMI_ACK);
            clk_en_ff      <= (nxt_state != ST_HALT) && !in_reset;
            snoop_ff       <= !in_reset;
            tri_ff         <= (nxt_state == ST_TRISTATE);
            // Idle status carries correct parity by definition
            rsp_valid_ff   <= rs_active && !in_reset;
            rsp_status_ff  <= ~bus.response_status_n;
            par_err_ff     <= rs_active && !rs_par_ok && !in_reset;
        end
    end

    assign o_req_ready        = req_ready_ff;
    assign o_core_reset       = core_reset_ff;
    assign o_cache_inval      = cache_inval_ff;
    assign o_cfg              = cfg_ff;
    assign o_cfg_valid        = cfg_valid_ff;
    assign o_sys_mgmt_state   = mgmt_ff;
    assign o_state_save       = save_ff;
    assign o_core_clk_en      = clk_en_ff;
    assign o_snoop_en         = snoop_ff;
    assign o_irq_service_en   = snoop_ff;
    assign o_outputs_tristate = tri_ff;
    assign o_rsp_status       = rsp_status_ff;
    assign o_rsp_valid        = rsp_valid_ff;
    assign o_parity_err       = par_err_ff;
endmodule
`default_nettype wire

// ### crs_chipset_end.sv
// Chipset end: power_ok and reset sequencing, config drive, sideband and response drive.
// Assumes the processor end on the same bus clock; user inputs are on that clock.
`timescale 1ns/1ps
`default_nettype none
module crs_chipset_end
    import crs_pkg::*;
#(
    parameter int CW       = CFG_W,
    parameter int RST_HOLD = RST_HOLD_CYC,
    parameter int CFG_HOLD = CFG_HOLD_CYC
)(
    // Clock, reset, enable
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // Link
    crs_sideband_if.host_mp       bus,
    // Board-side controls
    input  wire logic             i_supply_ok,
    input  wire logic             i_scan_active,
    input  wire logic             i_warm_reset,
    input  wire logic [CW-1:0]    i_cfg,
    input  wire logic             i_smi_req,
    input  wire logic             i_halt_req,
    input  wire logic             i_rsp_valid,
    input  wire logic [RSP_W-1:0] i_rsp_status,
    // Board-side status
    output logic                  o_power_ok,
    output logic                  o_in_reset,
    output logic                  o_req_seen,
    output logic [REQ_W-1:0]      o_req_cmd
);
    localparam int CNT_W = $clog2(RST_MAX_CYC + 1);

    if (RST_HOLD < 1 || RST_HOLD > RST_MAX_CYC || CFG_HOLD < CFG_HOLD_CYC ||
        CFG_HOLD >= RST_MAX_CYC) begin : g_chk
        $error("crs_chipset_end: RST_HOLD or CFG_HOLD out of range");
    end

    crs_host_state_t  state_ff;
    crs_host_state_t  nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Scan keeps power_ok up even if supplies are reported unstable
    wire pwr_keep = i_supply_ok || i_scan_active;
    wire cnt_done = (cnt_ff == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            HS_OFF: begin
                if (i_supply_ok) begin
                    nxt_state = HS_RESET;
                    nxt_cnt   = CNT_W'(RST_HOLD - 1);
                end
            end
            HS_RESET: begin
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_done) begin
                    nxt_state = HS_CFG;
                    nxt_cnt   = CNT_W'(CFG_HOLD - 1);
                end
            end
            HS_CFG: begin
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_done) begin
                    nxt_state = HS_RUN;
                end
            end
            HS_RUN: begin
                if (i_warm_reset) begin
                    nxt_state = HS_RESET;
                    nxt_cnt   = CNT_W'(RST_HOLD - 1);
                end
            end
            default: nxt_state = HS_OFF;
        endcase
        if (!pwr_keep) begin
            nxt_state = HS_OFF;
            nxt_cnt   = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    logic             pwr_ff;
    logic             rst_n_ff;
    logic             smi_n_ff;
    logic             halt_n_ff;
    logic             cfg_oe_n_ff;
    logic [CW-1:0]    cfg_ff;
    logic [RSP_W-1:0] rs_ff;
    logic             rsp_par_ff;
    logic             rs_oe_n_ff;
    logic             seen_ff;
    logic [REQ_W-1:0] cmd_ff;

    wire rs_drive = i_rsp_valid && (i_rsp_status != RS_IDLE) && (state_ff == HS_RUN);
    wire strobed  = (bus.address_strobe_n != '1);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff    <= HS_OFF;
            cnt_ff      <= '0;
            pwr_ff      <= 1'b0;
            rst_n_ff    <= 1'b0;
            smi_n_ff    <= 1'b1;
            halt_n_ff   <= 1'b1;
            cfg_oe_n_ff <= 1'b0;
            cfg_ff      <= '0;
            rs_ff       <= '1;
            rsp_par_ff  <= 1'b1;
            rs_oe_n_ff  <= 1'b1;
            seen_ff     <= 1'b0;
            cmd_ff      <= '0;
        end else if (i_ce) begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            pwr_ff      <= (nxt_state != HS_OFF);
            rst_n_ff    <= (nxt_state == HS_CFG) || (nxt_state == HS_RUN);
            smi_n_ff    <= !i_smi_req;
            halt_n_ff   <= !i_halt_req;
            // Config stays on the pins past release to cover the far end's synchroniser
            cfg_oe_n_ff <= (nxt_state == HS_RUN);
            cfg_ff      <= i_cfg;
            rs_ff       <= rs_drive ? ~i_rsp_status : '1;
            rsp_par_ff  <= rs_drive ? crs_rsp_parity(~i_rsp_status) : 1'b1;
            rs_oe_n_ff  <= !rs_drive;
            seen_ff     <= strobed;
            if (strobed) begin
                cmd_ff <= ~bus.request_cmd_n;
            end
        end
    end

    assign bus.power_ok         = pwr_ff;
    assign bus.reset_n          = rst_n_ff;
    assign bus.sys_mgmt_irq_n   = smi_n_ff;
    assign bus.clock_halt_req_n = halt_n_ff;
    assign bus.cfg_out          = cfg_ff;
    assign bus.cfg_oe_n         = cfg_oe_n_ff;
    assign bus.rsp_status_out   = rs_ff;
    assign bus.rsp_parity_out   = rsp_par_ff;
    assign bus.rsp_oe_n         = rs_oe_n_ff;
    assign o_power_ok           = pwr_ff;
    assign o_in_reset           = !rst_n_ff;
    assign o_req_seen           = seen_ff;
    assign o_req_cmd            = cmd_ff;
endmodule
`default_nettype wire

// ### crs_sideband_props.sv
// Checker for the wire side of the sideband link.
// Assumes one bus clock; instantiated by the bench beside the link.
`timescale 1ns/1ps
`default_nettype none
module crs_sideband_props
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic             i_core_clk,
    input wire logic             i_rst_n,
    // Link
    input wire logic             power_ok,
    input wire logic             reset_n,
    input wire logic             sys_mgmt_irq_n,
    input wire logic             clock_halt_req_n,
    input wire logic             cfg_oe_n,
    input wire logic             rsp_oe_n,
    input wire logic             req_oe_n,
    input wire logic             stb_oe_n,
    input wire logic [STB_W-1:0] stb_out,
    input wire logic [REQ_W-1:0] request_cmd_n,
    input wire logic [RSP_W-1:0] response_status_n,
    input wire logic             response_parity_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rel; !reset_n |-> ##[0:5] (req_oe_n && stb_oe_n); endproperty
    property p_par; !rsp_oe_n |-> response_parity_n == ~(^(~response_status_n)); endproperty
    property p_idle; !rsp_oe_n |-> response_status_n != '1; endproperty
    property p_pair; !req_oe_n |-> !stb_oe_n && stb_out == '0; endproperty
    property p_halt; !req_oe_n && request_cmd_n == ~CMD_HALT_ACK |-> !$past(clock_halt_req_n, 5);
    endproperty
    sequence s_smi_ack; !req_oe_n && request_cmd_n == ~CMD_SMI_ACK; endsequence
    property p_smi; $fell(sys_mgmt_irq_n) && reset_n |-> ##[4:12] s_smi_ack; endproperty
    property p_cfg; $rose(reset_n) |-> !cfg_oe_n [*4]; endproperty
    property p_pok; $rose(power_ok) |-> !reset_n [*8]; endproperty
    a_rel: assert property (p_rel) else $error("outputs held after bus reset");
    a_par: assert property (p_par) else $error("bad response parity");
    a_idle: assert property (p_idle) else $error("idle status driven");
    a_pair: assert property (p_pair) else $error("command without strobes");
    a_halt: assert property (p_halt) else $error("halt ack without request");
    a_smi: assert property (p_smi) else $error("no interrupt ack");
    a_cfg: assert property (p_cfg) else $error("config not held at release");
    a_pok: assert property (p_pok) else $error("no reset after power rise");
    c_halt: cover property (!req_oe_n && request_cmd_n == ~CMD_HALT_ACK);
    c_smi: cover property (s_smi_ack);
    c_rsp: cover property (!rsp_oe_n);
endmodule
`default_nettype wire

// ### tb_cpu_reset_sideband_control.sv
// Bench joining both ends of the sideband link, with a queue model of each transfer.
// Assumes shortened reset hold so the whole run stays brief.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_sideband_control;
    import crs_pkg::*;
    logic             clk, rst_n, sup, smi, halt, ureq, sexit, rv;
    logic             rdy, crst, cinv, cval, sys_mgmt_state, cken, snp, irqe, tri_s, rval, perr, seen;
    logic             scan, wrst, save, pok, inrst;
    logic [REQ_W-1:0] ucmd, ocmd;
    logic [RSP_W-1:0] rst, orsp;
    logic [CFG_W-1:0] cfg, ocfg;
    logic [6:0]       fl;
    int               error_cnt, num_checks, n_save;
    int               cq[$], rq[$];
    assign fl = {tri_s, crst, ~sys_mgmt_state, sys_mgmt_state, cken, ~cken, cval};
    crs_sideband_if crs_sideband_if_inst ();
    crs_cpu_end crs_cpu_end_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .bus(crs_sideband_if_inst), .i_user_req(ureq), .i_user_cmd(ucmd), .i_smm_exit(sexit),
        .o_req_ready(rdy), .o_core_reset(crst), .o_cache_inval(cinv), .o_cfg(ocfg),
        .o_cfg_valid(cval), .o_sys_mgmt_state(sys_mgmt_state), .o_state_save(save), .o_core_clk_en(cken),
        .o_snoop_en(snp), .o_irq_service_en(irqe), .o_outputs_tristate(tri_s),
        .o_rsp_status(orsp), .o_rsp_valid(rval), .o_parity_err(perr));
    crs_chipset_end #(.RST_HOLD(20), .CFG_HOLD(6)) crs_chipset_end_inst (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_ce(1'b1), .bus(crs_sideband_if_inst), .i_supply_ok(sup),
        .i_scan_active(scan), .i_warm_reset(wrst), .i_cfg(cfg), .i_smi_req(smi),
        .i_halt_req(halt), .i_rsp_valid(rv), .i_rsp_status(rst), .o_power_ok(pok),
        .o_in_reset(inrst), .o_req_seen(seen), .o_req_cmd(ocmd));
    crs_sideband_props crs_sideband_props_inst (.i_core_clk(clk), .i_rst_n(rst_n),
        .power_ok(crs_sideband_if_inst.power_ok), .reset_n(crs_sideband_if_inst.reset_n),
        .sys_mgmt_irq_n(crs_sideband_if_inst.sys_mgmt_irq_n),
        .clock_halt_req_n(crs_sideband_if_inst.clock_halt_req_n),
        .cfg_oe_n(crs_sideband_if_inst.cfg_oe_n), .rsp_oe_n(crs_sideband_if_inst.rsp_oe_n),
        .req_oe_n(crs_sideband_if_inst.req_oe_n), .stb_oe_n(crs_sideband_if_inst.stb_oe_n),
        .stb_out(crs_sideband_if_inst.stb_out),
        .request_cmd_n(crs_sideband_if_inst.request_cmd_n),
        .response_status_n(crs_sideband_if_inst.response_status_n),
        .response_parity_n(crs_sideband_if_inst.response_parity_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_f(input logic g, input logic e);
        chk_v({7'h00, g}, {7'h00, e});
    endtask
    task automatic wt(input int s);
        int n;
        for (n = 0; n < 2000 && fl[s] !== 1'b1; n++) @(posedge clk);
        if (n == 2000) begin
            error_cnt++;
            $display("ERROR %0t wait %0d timed out", $time, s);
            summarize();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Model: what each end takes is queued, the far end must deliver it in order
    always @(posedge clk) begin
        if (ureq === 1'b1 && rdy === 1'b1) cq.push_back(ucmd);
        if (rv === 1'b1 && rst != 3'h0) rq.push_back(rst);
        if (save === 1'b1) n_save++;
        if (seen === 1'b1) chk_v(8'(ocmd), 8'(cq.pop_front()));
        if (rval === 1'b1) begin
            chk_v(8'(orsp), 8'(rq.pop_front()));
            chk_f(perr, 1'b0);
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        void'($urandom(52529));
        {rst_n, sup, smi, halt, ureq, sexit, rv, scan, wrst} = 9'h000;
        ucmd = 5'h00_00;
        rst = 3'h0;
        cfg = 8'($urandom);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_f(cinv, 1'b1);
        @(posedge clk);
        sup <= 1'b1;
        wt(0);
        chk_v(ocfg, cfg);
        $display("test power-up done");
        repeat (10) @(posedge clk);
        // Bit 3 cleared keeps user codes apart from the two ack codes
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            ureq <= 1'b1;
            ucmd <= 5'($urandom) & 5'h17;
            rv <= 1'b1;
            rst <= 3'($urandom);
        end
        @(posedge clk);
        ureq <= 1'b0;
        rv <= 1'b0;
        repeat (4) @(posedge clk);
        chk_v(8'(cq.size() + rq.size()), 8'h00);
        $display("test traffic done");
        // Each grant or interrupt acknowledge must reach the chipset as a command
        cq.push_back(CMD_HALT_ACK);
        halt <= 1'b1;
        wt(1);
        chk_f(snp & irqe, 1'b1);
        halt <= 1'b0;
        wt(2);
        cq.push_back(CMD_SMI_ACK);
        smi <= 1'b1;
        wt(3);
        repeat (4) @(posedge clk);
        chk_v(8'(n_save), 8'h01);
        sexit <= 1'b1;
        @(posedge clk);
        sexit <= 1'b0;
        smi <= 1'b0;
        wt(4);
        $display("test halt and interrupt done");
        wrst <= 1'b1;
        cfg <= 8'($urandom);
        @(posedge clk);
        wrst <= 1'b0;
        wt(5);
        chk_f(cinv, 1'b1);
        wt(0);
        chk_v(ocfg, cfg);
        $display("test warm reset done");
        scan <= 1'b1;
        sup <= 1'b0;
        repeat (8) @(posedge clk);
        chk_f(pok & ~crst, 1'b1);
        scan <= 1'b0;
        wt(5);
        chk_f(inrst & ~pok, 1'b1);
        smi <= 1'b1;
        sup <= 1'b1;
        wt(6);
        chk_f(crs_sideband_if_inst.req_oe_n & crs_sideband_if_inst.stb_oe_n, 1'b1);
        chk_v(8'(cq.size() + rq.size()), 8'h00);
        $display("test power drop done");
        summarize();
    end
endmodule
`default_nettype wire
